// ---- core/gtp_timers.v ----
// Timer group top: 16-bit timer with five channels, two 8-bit timers, IR mode.
`timescale 1ns/100ps
`default_nettype none
module gtp_timers
#(
	parameter NCH = 5 // Number of channels of the 16-bit timer.
)
(
	input  wire         ref_clk_i,      // System clock, 100 MHz.
	input  wire         rst_n_i,        // Asynchronous active-low reset.
	input  wire         evt_i,          // Event input for counter mode.
	input  wire [4:0]   cap_i,          // Capture inputs, one per channel.
	output reg  [4:0]   pwm16_o,        // PWM outputs of the 16-bit timer.
	output reg          pwm8a_o,        // PWM output of first 8-bit timer.
	output reg          pwm8b_o,        // PWM output of second 8-bit timer.
	output reg          ir_o,           // Modulated infrared output.
	input  wire [31:0]  s_axi_awaddr,   // Write address.
	input  wire         s_axi_awvalid,  // Write address valid.
	output reg          s_axi_awready,  // Write address ready.
	input  wire [31:0]  s_axi_wdata,    // Write data.
	input  wire [3:0]   s_axi_wstrb,    // Write byte strobes.
	input  wire         s_axi_wvalid,   // Write data valid.
	output reg          s_axi_wready,   // Write data ready.
	output reg  [1:0]   s_axi_bresp,    // Write response.
	output reg          s_axi_bvalid,   // Write response valid.
	input  wire         s_axi_bready,   // Write response ready.
	input  wire [31:0]  s_axi_araddr,   // Read address.
	input  wire         s_axi_arvalid,  // Read address valid.
	output reg          s_axi_arready,  // Read address ready.
	output reg  [31:0]  s_axi_rdata,    // Read data.
	output reg  [1:0]   s_axi_rresp,    // Read response.
	output reg          s_axi_rvalid,   // Read valid.
	input  wire         s_axi_rready    // Read ready.
);
`include "gtp_regs.vh"
	// ======================================================================
	// Register storage.
	// ======================================================================
	reg  [31:0] ctrl_reg;           // Enables and mode bits.
	reg  [15:0] pre16_reg;          // 16-bit timer prescaler.
	reg  [15:0] per16_reg;          // 16-bit timer period.
	reg  [15:0] cmp_reg [0:4];      // Channel compare values.
	reg  [15:0] cap_reg [0:4];      // Channel captured counts.
	reg  [4:0]  mode_reg;           // Per channel: 1 capture, 0 PWM.
	reg  [23:0] t8a_reg;            // First 8-bit: cmp, per, pre.
	reg  [23:0] t8b_reg;            // Second 8-bit: cmp, per, pre.
	reg  [15:0] cnt16_reg;          // 16-bit count.
	reg  [4:0]  cap_d_reg;          // Previous capture input level.
	reg         evt_d_reg;          // Previous event input level.
	// Write path holding registers.
	reg         aw_hold_reg;        // Address taken.
	reg         w_hold_reg;         // Data taken.
	reg  [7:0]  waddr_reg;          // Held write address.
	reg  [31:0] wdata_reg;          // Held write data.
	reg  [3:0]  wstrb_reg;          // Held strobes.
	wire        tick16;             // Prescaled tick of 16-bit timer.
	wire        wrap8a;             // Period end of first 8-bit timer.
	wire        pwm8a;              // First 8-bit PWM.
	wire        pwm8b;              // Second 8-bit PWM.
	wire [7:0]  cnt8a;              // First 8-bit count.
	wire [7:0]  cnt8b;              // Second 8-bit count.
	wire        ir_mode = ctrl_reg[`GTP_CTRL_IR_EN];
	wire        evt_mode = ctrl_reg[`GTP_CTRL_EVT_EN];
	wire        en16 = ctrl_reg[`GTP_CTRL_T16_EN];
	wire        evt_rise = evt_i && !evt_d_reg;
	// The advance source depends on mode; IR mode takes priority over event mode.
	// An event edge that arrives in IR mode is dropped on purpose: the carrier
	// wrap is the only clock of the 16-bit count there.
	wire        adv16 = en16 && (ir_mode ? wrap8a : (evt_mode ? evt_rise : tick16));
	// Each of the two clocked processes with a loop has its own loop index, so no variable has two drivers.
	integer     i;                  // Loop index of the counter process.
	integer     j;                  // Loop index of the register write process.
	// ======================================================================
	// Prescaler of the 16-bit timer and the two 8-bit timers.
	// A prescaler is held cleared while its timer is off, so the first tick after
	// an enable comes one full ratio later.
	// ======================================================================
	gtp_tick u_tick16
	(
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.en_i      (en16),
		.div_i     (pre16_reg),
		.tick_o    (tick16)
	);
	gtp_timer8 u_t8a
	(
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.en_i      (ctrl_reg[`GTP_CTRL_T8A_EN]),
		.pre_i     (t8a_reg[7:0]),
		.per_i     (t8a_reg[15:8]),
		.cmp_i     (t8a_reg[23:16]),
		.cnt_o     (cnt8a),
		.wrap_o    (wrap8a),
		.pwm_o     (pwm8a)
	);
	gtp_timer8 u_t8b
	(
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.en_i      (ctrl_reg[`GTP_CTRL_T8B_EN]),
		.pre_i     (t8b_reg[7:0]),
		.per_i     (t8b_reg[15:8]),
		.cmp_i     (t8b_reg[23:16]),
		.cnt_o     (cnt8b),
		.wrap_o    (),
		.pwm_o     (pwm8b)
	);
	// ======================================================================
	// 16-bit counter, channel compare and capture, outputs.
	// ======================================================================
	// The count is cleared whenever the timer is off, so a restart always begins
	// at zero. Capture takes the count as it stands before the edge that sees the
	// input rise; cap_i is sampled directly, so the value carries no synchroniser delay.
	// All pin outputs are registered here, at the cost of one cycle of latency.
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt16_reg <= `GTP_ZERO16;
			cap_d_reg <= 5'h0;
			evt_d_reg <= 1'b0;
			pwm16_o   <= 5'h0;
			pwm8a_o   <= 1'b0;
			pwm8b_o   <= 1'b0;
			ir_o      <= 1'b0;
			for (i = 0; i < NCH; i = i + 1)
				cap_reg[i] <= `GTP_ZERO16;
		end
		else
		begin
			evt_d_reg <= evt_i;
			cap_d_reg <= cap_i;
			if (!en16)
				cnt16_reg <= `GTP_ZERO16;
			else if (adv16)
			begin
				if (cnt16_reg >= per16_reg)
					cnt16_reg <= `GTP_ZERO16;
				else
					cnt16_reg <= cnt16_reg + `GTP_ONE16;
			end
			for (i = 0; i < NCH; i = i + 1)
			begin
				// Capture on a rising input edge; PWM pins stay low in capture mode.
				if (mode_reg[i] && cap_i[i] && !cap_d_reg[i])
					cap_reg[i] <= cnt16_reg;
				pwm16_o[i] <= en16 && !mode_reg[i] && (cnt16_reg < cmp_reg[i]);
			end
			pwm8a_o <= pwm8a;
			pwm8b_o <= pwm8b;
			// Channel 0 gates the carrier of the first 8-bit timer.
			ir_o <= ir_mode && en16 && !mode_reg[0] && (cnt16_reg < cmp_reg[0]) && pwm8a;
		end
	end
	// ======================================================================
	// AXI4-Lite write channel: address and data in either order.
	// Each ready is raised for one cycle and then dropped, so a beat can never be
	// taken twice; the price is one idle cycle per channel between transfers.
	// The response is held until the master takes it, and no new beat is taken
	// meanwhile.
	// ======================================================================
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			waddr_reg     <= 8'h00;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			ctrl_reg      <= `GTP_CTRL_RST;
			pre16_reg     <= `GTP_ZERO16;
			per16_reg     <= `GTP_PER16_RST;
			mode_reg      <= 5'h0;
			t8a_reg       <= {`GTP_ZERO8, `GTP_PER8_RST, `GTP_ZERO8};
			t8b_reg       <= {`GTP_ZERO8, `GTP_PER8_RST, `GTP_ZERO8};
			// Compares start at zero, so every PWM output is low until software writes one.
			for (j = 0; j < NCH; j = j + 1)
				cmp_reg[j] <= `GTP_ZERO16;
		end
		else
		begin
			// Ready is offered one cycle ahead so each channel takes one beat.
			s_axi_awready <= !aw_hold_reg && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_hold_reg && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_reg <= 1'b1;
				waddr_reg   <= s_axi_awaddr[7:0];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_hold_reg && w_hold_reg && !s_axi_bvalid)
			begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'b00;
				// Only the low strobe is honoured, for control and mode; others are written whole.
				// Writes to the count and capture words are accepted with an OKAY
				// response and dropped, so a driver that restores a whole block of
				// registers does not see an error. Any other address outside the map
				// answers with a slave error and changes nothing.
				case (waddr_reg)
					`GTP_CTRL_OFF:    if (wstrb_reg[0]) ctrl_reg[4:0] <= wdata_reg[4:0];
					`GTP_T16_PRE_OFF: pre16_reg <= wdata_reg[15:0];
					`GTP_T16_PER_OFF: per16_reg <= wdata_reg[15:0];
					`GTP_CH_MODE_OFF: if (wstrb_reg[0]) mode_reg <= wdata_reg[4:0];
					`GTP_T8A_CFG_OFF: t8a_reg <= wdata_reg[23:0];
					`GTP_T8B_CFG_OFF: t8b_reg <= wdata_reg[23:0];
					`GTP_CH_CMP_OFF + 8'h00: cmp_reg[0] <= wdata_reg[15:0];
					`GTP_CH_CMP_OFF + 8'h04: cmp_reg[1] <= wdata_reg[15:0];
					`GTP_CH_CMP_OFF + 8'h08: cmp_reg[2] <= wdata_reg[15:0];
					`GTP_CH_CMP_OFF + 8'h0C: cmp_reg[3] <= wdata_reg[15:0];
					`GTP_CH_CMP_OFF + 8'h10: cmp_reg[4] <= wdata_reg[15:0];
					`GTP_T16_CNT_OFF, `GTP_T8_CNT_OFF,
					`GTP_CH_CAP_OFF + 8'h00, `GTP_CH_CAP_OFF + 8'h04,
					`GTP_CH_CAP_OFF + 8'h08, `GTP_CH_CAP_OFF + 8'h0C,
					`GTP_CH_CAP_OFF + 8'h10: s_axi_bresp <= 2'b00;
					default: s_axi_bresp <= 2'b10; // Unmapped address.
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	// ======================================================================
	// AXI4-Lite read channel.
	// The address is decoded in the cycle it is taken and the data stands in the
	// next one, so a read costs at least three cycles; only one read is open at a time.
	// ======================================================================
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= 2'b00;
				// Every register sits in the low bits of its word and the unused upper
				// bits read as zero. Counts and captures are live values, so a read of
				// a running count returns the value at the edge that takes the address.
				case (s_axi_araddr[7:0])
					`GTP_CTRL_OFF:    s_axi_rdata <= {27'h0, ctrl_reg[4:0]};
					`GTP_T16_PRE_OFF: s_axi_rdata <= {16'h0, pre16_reg};
					`GTP_T16_PER_OFF: s_axi_rdata <= {16'h0, per16_reg};
					`GTP_T16_CNT_OFF: s_axi_rdata <= {16'h0, cnt16_reg};
					`GTP_CH_MODE_OFF: s_axi_rdata <= {27'h0, mode_reg};
					`GTP_T8A_CFG_OFF: s_axi_rdata <= {8'h0, t8a_reg};
					`GTP_T8B_CFG_OFF: s_axi_rdata <= {8'h0, t8b_reg};
					`GTP_T8_CNT_OFF:  s_axi_rdata <= {16'h0, cnt8b, cnt8a};
					`GTP_CH_CMP_OFF + 8'h00: s_axi_rdata <= {16'h0, cmp_reg[0]};
					`GTP_CH_CMP_OFF + 8'h04: s_axi_rdata <= {16'h0, cmp_reg[1]};
					`GTP_CH_CMP_OFF + 8'h08: s_axi_rdata <= {16'h0, cmp_reg[2]};
					`GTP_CH_CMP_OFF + 8'h0C: s_axi_rdata <= {16'h0, cmp_reg[3]};
					`GTP_CH_CMP_OFF + 8'h10: s_axi_rdata <= {16'h0, cmp_reg[4]};
					`GTP_CH_CAP_OFF + 8'h00: s_axi_rdata <= {16'h0, cap_reg[0]};
					`GTP_CH_CAP_OFF + 8'h04: s_axi_rdata <= {16'h0, cap_reg[1]};
					`GTP_CH_CAP_OFF + 8'h08: s_axi_rdata <= {16'h0, cap_reg[2]};
					`GTP_CH_CAP_OFF + 8'h0C: s_axi_rdata <= {16'h0, cap_reg[3]};
					`GTP_CH_CAP_OFF + 8'h10: s_axi_rdata <= {16'h0, cap_reg[4]};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10; // Unmapped address.
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // gtp_timers
`default_nettype wire

// ---- core/gtp_regs.vh ----
// Register map and field constants of the general timer group.
`ifndef GTP_REGS_VH
`define GTP_REGS_VH
// ==========================================================================
// Register byte offsets.
// ==========================================================================
`define GTP_CTRL_OFF      8'h00
`define GTP_T16_PRE_OFF   8'h04
`define GTP_T16_PER_OFF   8'h08
`define GTP_T16_CNT_OFF   8'h0C
`define GTP_CH_CMP_OFF    8'h10
`define GTP_CH_CAP_OFF    8'h24
`define GTP_CH_MODE_OFF   8'h38
`define GTP_T8A_CFG_OFF   8'h3C
`define GTP_T8B_CFG_OFF   8'h40
`define GTP_T8_CNT_OFF    8'h44
// ==========================================================================
// Control register field positions.
// ==========================================================================
`define GTP_CTRL_T16_EN   0
`define GTP_CTRL_T8A_EN   1
`define GTP_CTRL_T8B_EN   2
`define GTP_CTRL_IR_EN    3
`define GTP_CTRL_EVT_EN   4
// ==========================================================================
// Reset values.
// ==========================================================================
`define GTP_CTRL_RST      32'h0000_0000
`define GTP_PER16_RST     16'hFFFF
`define GTP_PER8_RST      8'hFF
`define GTP_ZERO16        16'h0000
`define GTP_ZERO8         8'h00
`define GTP_ONE16         16'h0001
`define GTP_ONE8          8'h01
`endif

// ---- core/gtp_tick.v ----
// Prescaler producing one-cycle count ticks.
`timescale 1ns/100ps
`default_nettype none
module gtp_tick
(
	input  wire        ref_clk_i,  // System clock.
	input  wire        rst_n_i,    // Asynchronous active-low reset.
	input  wire        en_i,       // Run enable.
	input  wire [15:0] div_i,      // Divide by div_i plus one.
	output reg         tick_o      // One-cycle tick.
);
`include "gtp_regs.vh"
	reg [15:0] cnt_reg; // Cycles since last tick.
	// ======================================================================
	// Divider: a ratio change applies to the period in progress, as the count is compared with the live div_i.
	// ======================================================================
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_reg <= `GTP_ZERO16;
			tick_o  <= 1'b0;
		end
		else if (!en_i)
		begin
			cnt_reg <= `GTP_ZERO16;
			tick_o  <= 1'b0;
		end
		else if (cnt_reg >= div_i)
		begin
			cnt_reg <= `GTP_ZERO16;
			tick_o  <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + `GTP_ONE16;
			tick_o  <= 1'b0;
		end
	end
endmodule // gtp_tick
`default_nettype wire

// ---- core/gtp_timer8.v ----
// Eight-bit timer with one compare channel driving PWM.
`timescale 1ns/100ps
`default_nettype none
module gtp_timer8
(
	input  wire       ref_clk_i,  // System clock.
	input  wire       rst_n_i,    // Asynchronous active-low reset.
	input  wire       en_i,       // Timer enable.
	input  wire [7:0] pre_i,      // Prescaler ratio minus one.
	input  wire [7:0] per_i,      // Period value.
	input  wire [7:0] cmp_i,      // Compare value.
	output wire [7:0] cnt_o,      // Running count.
	output reg        wrap_o,     // One-cycle pulse on period end.
	output reg        pwm_o       // PWM output, high while count below compare.
);
`include "gtp_regs.vh"
	wire       tick;    // Prescaled tick.
	reg  [7:0] cnt_reg; // Count.
	assign cnt_o = cnt_reg;
	gtp_tick u_tick
	(
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.en_i      (en_i),
		.div_i     ({8'h00, pre_i}),
		.tick_o    (tick)
	);
	// ======================================================================
	// Counter, wrap pulse and PWM compare.
	// ======================================================================
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_reg <= `GTP_ZERO8;
			wrap_o  <= 1'b0;
			pwm_o   <= 1'b0;
		end
		else
		begin
			wrap_o <= 1'b0;
			if (!en_i)
				cnt_reg <= `GTP_ZERO8;
			else if (tick)
			begin
				if (cnt_reg >= per_i)
				begin
					cnt_reg <= `GTP_ZERO8;
					wrap_o  <= 1'b1;
				end
				else
					cnt_reg <= cnt_reg + `GTP_ONE8;
			end
			pwm_o <= en_i && (cnt_reg < cmp_i);
		end
	end
endmodule // gtp_timer8
`default_nettype wire

// ---- bench/gtp_pin_model.sv ----
// Pin-side model that drives the event and capture inputs.
`timescale 1ns/100ps
`default_nettype none
module gtp_pin_model
(
	input  wire logic       ref_clk_i, // System clock.
	output var  logic       evt_o,     // Event pin, idle low.
	output var  logic [4:0] cap_o      // Capture pins, idle low.
);
	// ==================================================================
	// Edge generation
	// ==================================================================
	// The pins are driven actively, so they stay at a defined level between edges.
	initial
	begin
		evt_o = 1'b0;
		cap_o = 5'h0;
	end
	// Pin 5 is the event pin and 0 to 4 are the capture pins.
	// Each phase lasts hold cycles, so edges come quickly or slowly.
	task pulse(input int pin, input int hold);
		repeat (2)
		begin
			@(posedge ref_clk_i);
			if (pin == 5)
				evt_o <= ~evt_o;
			else
				cap_o[pin] <= ~cap_o[pin];
			repeat (hold - 1) @(posedge ref_clk_i);
		end
	endtask
endmodule // gtp_pin_model
`default_nettype wire

// ---- bench/gtp_timers_sva.sv ----
// Concurrent checks of the timer group top ports.
`timescale 1ns/100ps
`default_nettype none
module gtp_timers_sva
(
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic [4:0]  pwm16_o,
	input wire logic        ir_o,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	// ==================================================================
	// Sequences
	// ==================================================================
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// A response that the master has not yet accepted.
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	sequence s_r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	// A read address taken beyond the last mapped register.
	sequence s_bad_ar;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] > 8'h44;
	endsequence
	// ==================================================================
	// Assertions
	// ==================================================================
	a_bvalid_held: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rvalid_held: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while read pending");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_wready_pulse: assert property (s_axi_wready |=> !s_axi_wready)
		else $error("write ready not alternating");
	a_bad_read: assert property (s_bad_ar |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_ir_gated: assert property (ir_o |-> pwm16_o[0])
		else $error("infrared output high without channel zero");
endmodule // gtp_timers_sva
bind gtp_timers gtp_timers_sva i_gtp_timers_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.pwm16_o(pwm16_o), .ir_o(ir_o), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready));
`default_nettype wire

// ---- bench/test_gtp_timers.sv ----
// Self-checking bench of the timer group.
`timescale 1ns/100ps
`default_nettype none
module test_gtp_timers;
	logic        ref_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        evt_i;
	logic [4:0]  cap_i;
	logic [4:0]  pwm16_o;
	logic        pwm8a_o, pwm8b_o, ir_o;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] d;
	int          error_cnt = 0;
	int          num_checks = 0;
	int          hi [8];
	int          cv [5] = '{0, 1, 2, 3, 6};
	// ==================================================================
	// Design and pins
	// ==================================================================
	always #5 ref_clk_i = ~ref_clk_i;
	gtp_pin_model i_gtp_pin_model (.ref_clk_i(ref_clk_i), .evt_o(evt_i), .cap_o(cap_i));
	gtp_timers i_gtp_timers (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .evt_i(evt_i),
		.cap_i(cap_i), .pwm16_o(pwm16_o), .pwm8a_o(pwm8a_o), .pwm8b_o(pwm8b_o), .ir_o(ir_o),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	// ==================================================================
	// Shared tasks
	// ==================================================================
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// A slow master leaves the response waiting, which exercises the hold checks.
	task wr(input logic [7:0] a, input logic [31:0] v, input bit slow);
		bit ad, wd;
		ad = 0;
		wd = 0;
		@(posedge ref_clk_i);
		awaddr <= {24'h00_0000, a};
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !slow;
		while (!(ad && wd))
		begin
			@(posedge ref_clk_i);
			if (!ad && awready === 1'b1)
			begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1)
			begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk_i); while (bvalid !== 1'b1);
		if (slow)
		begin
			repeat (2) @(posedge ref_clk_i);
			bready <= 1'b1;
			@(posedge ref_clk_i);
		end
		r = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input bit slow);
		@(posedge ref_clk_i);
		araddr <= {24'h00_0000, a};
		arvalid <= 1'b1;
		rready <= !slow;
		do @(posedge ref_clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge ref_clk_i); while (rvalid !== 1'b1);
		if (slow)
		begin
			rready <= 1'b1;
			@(posedge ref_clk_i);
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// High cycles of every output over a window of whole periods.
	task measure(input int n);
		hi = '{default: 0};
		repeat (n)
		begin
			@(posedge ref_clk_i);
			for (int i = 0; i < 5; i++) hi[i] += pwm16_o[i];
			hi[5] += pwm8a_o;
			hi[6] += pwm8b_o;
			hi[7] += ir_o;
		end
	endtask
	// ==================================================================
	// Scenarios
	// ==================================================================
	task t_reset();
		rd(8'h00, 1'b0);
		chk(d, 32'h0000_0000);
		rd(8'h08, 1'b1);
		chk(d, 32'h0000_FFFF);
		rd(8'h3C, 1'b0);
		chk({24'h00_0000, d[15:8]}, 32'h0000_00FF);
		rd(8'h80, 1'b0);
		chk(d, 32'h0000_0000);
		chk({30'h0, r}, 32'h0000_0002);
		$display("test reset done");
	endtask
	// Prescale 4, period 5: each channel is high cmp*4 of every 24 cycles.
	task t_pwm16();
		for (int i = 0; i < 5; i++) wr(8'h10 + 8'(4 * i), cv[i], 1'b0);
		wr(8'h38, 32'h0000_0000, 1'b0);
		wr(8'h04, 32'h0000_0003, 1'b0);
		wr(8'h08, 32'h0000_0005, 1'b0);
		wr(8'h00, 32'h0000_0001, 1'b1);
		repeat (50) @(posedge ref_clk_i);
		measure(96);
		for (int i = 0; i < 5; i++) chk(hi[i], 16 * cv[i]);
		chk(hi[7], 0);
		wr(8'h00, 32'h0000_0000, 1'b0);
		$display("test pwm16 done");
	endtask
	task t_pwm8();
		wr(8'h3C, 32'h0002_0301, 1'b0);
		wr(8'h40, 32'h0005_0900, 1'b0);
		wr(8'h00, 32'h0000_0006, 1'b0);
		repeat (30) @(posedge ref_clk_i);
		measure(80);
		chk(hi[5], 40);
		chk(hi[6], 40);
		chk(hi[0], 0);
		wr(8'h00, 32'h0000_0000, 1'b0);
		$display("test pwm8 done");
	endtask
	// The small timer wraps every 4 cycles, so the big count steps every 4 cycles.
	task t_ir();
		wr(8'h3C, 32'h0002_0300, 1'b0);
		wr(8'h08, 32'h0000_0003, 1'b0);
		wr(8'h10, 32'h0000_0002, 1'b0);
		wr(8'h00, 32'h0000_000B, 1'b0);
		repeat (40) @(posedge ref_clk_i);
		measure(160);
		chk(hi[0], 80);
		chk(hi[7], 40);
		wr(8'h00, 32'h0000_0000, 1'b0);
		$display("test ir done");
	endtask
	task t_capture();
		wr(8'h04, 32'h0000_0000, 1'b0);
		wr(8'h08, 32'h0000_FFFF, 1'b0);
		wr(8'h38, 32'h0000_0002, 1'b0);
		// Compare 1 above the final count, so only capture mode keeps pin 1 low.
		wr(8'h14, 32'h0000_0010, 1'b0);
		wr(8'h00, 32'h0000_0011, 1'b0);
		for (int i = 0; i < 7; i++) i_gtp_pin_model.pulse(5, 1 + i % 3);
		rd(8'h0C, 1'b0);
		chk(d, 32'h0000_0007);
		i_gtp_pin_model.pulse(1, 2);
		i_gtp_pin_model.pulse(0, 2);
		rd(8'h28, 1'b1);
		chk(d, 32'h0000_0007);
		rd(8'h24, 1'b0);
		chk(d, 32'h0000_0000);
		chk({31'h0, pwm16_o[1]}, 32'h0000_0000);
		wr(8'h0C, 32'h0000_1234, 1'b0);
		chk({30'h0, r}, 32'h0000_0000);
		rd(8'h0C, 1'b0);
		chk(d, 32'h0000_0007);
		wr(8'h80, 32'h0000_0001, 1'b1);
		chk({30'h0, r}, 32'h0000_0002);
		$display("test capture done");
	endtask
	// ==================================================================
	// Sequence, watchdog and verdict
	// ==================================================================
	task final_report();
		$display("Checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_pwm16();
		t_pwm8();
		t_ir();
		t_capture();
		final_report();
	end
	// The scenarios need about 700 cycles; a hang is cut off well beyond that.
	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		error_cnt++;
		final_report();
	end
endmodule // test_gtp_timers
`default_nettype wire
